/* File: shared/fsp_pkg.sv */
// Package of constants and types for the flash status and write-protect block.
package fsp_pkg;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int CLK_PERIOD_NS = 20;
   localparam int OP_TIME_NS = 2000;
   localparam int OP_CYCLES_INT = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] OP_CYCLES = 12'(OP_CYCLES_INT);

   // ==========================================================================
   // Command codes
   // ==========================================================================
   localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
   localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
   localparam logic [7:0] CMD_RD_STATUS_LO = 8'h05;
   localparam logic [7:0] CMD_RD_STATUS_HI = 8'h35;
   localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
   localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
   localparam logic [7:0] CMD_QUAD_PAGE_WRITE = 8'h32;
   localparam logic [7:0] CMD_ERASE_4K = 8'h20;
   localparam logic [7:0] CMD_ERASE_32K = 8'h52;
   localparam logic [7:0] CMD_ERASE_64K = 8'hD8;
   localparam logic [7:0] CMD_ERASE_ALL_A = 8'hC7;
   localparam logic [7:0] CMD_ERASE_ALL_B = 8'h60;
   localparam logic [7:0] CMD_RESET_ARM = 8'h66;
   localparam logic [7:0] CMD_RESET_GO = 8'h99;
   localparam logic [7:0] CMD_SUSPEND = 8'h75;
   localparam logic [7:0] CMD_RESUME = 8'h7A;
   localparam logic [7:0] CMD_PERF_EXIT = 8'hAB;
   localparam logic [7:0] CMD_PERF_ENTER = 8'hA3;

   // ==========================================================================
   // Status word layout
   // ==========================================================================
   localparam int BIT_BUSY = 0;
   localparam int BIT_LATCH = 1;
   localparam int BIT_GUARD_LO = 2;
   localparam int BIT_SR_GUARD_LO = 7;
   localparam int BIT_SR_GUARD_HI = 8;
   localparam int BIT_QUAD = 9;
   localparam int BIT_SEC_LOCK = 10;
   localparam int BIT_PERF = 13;
   localparam int BIT_COMPL = 14;
   localparam int BIT_PAUSED = 15;
   localparam logic [15:0] STATUS_RESET = 16'h0000;

   // ==========================================================================
   // Frame lengths in whole bytes, and the sector count of the array
   // ==========================================================================
   localparam logic [2:0] BYTES_SINGLE = 3'h1;
   localparam logic [2:0] BYTES_SR_ONE = 3'h2;
   localparam logic [2:0] BYTES_SR_TWO = 3'h3;
   localparam logic [2:0] BYTES_ERASE = 3'h4;
   localparam logic [2:0] BYTES_PROG_MIN = 3'h5;
   localparam logic [2:0] BYTES_SAT = 3'h7;
   localparam logic [2:0] BYTES_HDR = 3'h4;
   localparam logic [6:0] SECTOR_COUNT = 7'h40;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef struct packed {
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [2:0] bytes;
      logic [2:0] bitpos;
   } fsp_frame_t;

   typedef enum logic [2:0] {
      FSP_OP_NONE,
      FSP_OP_PROG,
      FSP_OP_ERASE_4K,
      FSP_OP_ERASE_32K,
      FSP_OP_ERASE_64K,
      FSP_OP_ERASE_ALL
   } fsp_op_t;

   typedef struct packed {
      fsp_op_t kind;
      logic [23:0] addr;
   } fsp_array_req_t;

   typedef enum logic [1:0] {
      FSP_IDLE,
      FSP_BUSY,
      FSP_PAUSED
   } fsp_state_t;

endpackage

/* File: src/fsp_link.sv */
// Serial-clock side of the status block: frame capture and status read-out.
`timescale 1ns/100ps
`default_nettype none
module fsp_link import fsp_pkg::*; (
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   input wire logic [15:0] snap,
   output var fsp_frame_t frame,
   output logic so,
   output logic so_oe_n
);

   logic [31:0] hdr;
   logic [2:0] bitpos;
   logic [2:0] bytes;
   logic [2:0] next_bitpos, next_bytes, held_bitpos, held_bytes;
   logic rd_lo;
   logic rd_hi;
   logic [7:0] rd_byte;

   // ==========================================================================
   // Bit and byte counting, cleared by the frame's own select.
   // ==========================================================================
   assign next_bitpos = bitpos + 3'h1;
   assign next_bytes = (bitpos == 3'h7 && bytes != BYTES_SAT) ? bytes + 3'h1 : bytes;

   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bitpos <= 3'h0;
         bytes <= 3'h0;
      end else begin
         bitpos <= next_bitpos;
         bytes <= next_bytes;
      end
   end

   // Select clears the counters at once, so this copy keeps the length for the core side.
   // A select pulse with no clock edge at all would show the previous length again.
   always_ff @(posedge sclk) begin
      held_bitpos <= next_bitpos;
      held_bytes <= next_bytes;
   end

   // Opcode and address bytes are stored MSB first; later bytes are not kept.
   always_ff @(posedge sclk) begin
      if (bytes < BYTES_HDR) begin
         hdr[~{bytes[1:0], bitpos}] <= si;
      end
   end

   assign frame = '{opcode: hdr[31:24], addr: hdr[23:0], bytes: held_bytes, bitpos: held_bitpos};

   // ==========================================================================
   // Status read-out on the falling edge, repeating the selected byte.
   // ==========================================================================
   assign rd_lo = (bytes != 3'h0) && (hdr[31:24] == CMD_RD_STATUS_LO);
   assign rd_hi = (bytes != 3'h0) && (hdr[31:24] == CMD_RD_STATUS_HI);
   assign rd_byte = rd_hi ? snap[15:8] : snap[7:0];

   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         so <= 1'b0;
         so_oe_n <= 1'b1;
      end else if (rd_lo || rd_hi) begin
         so_oe_n <= 1'b0;
         so <= rd_byte[3'h7 - bitpos];
      end
   end

endmodule
`default_nettype wire

/* File: src/fsp_status_protect.sv */
// Status word and write-protection logic of a serial flash, core-clock side.
`timescale 1ns/100ps
`default_nettype none
module fsp_status_protect import fsp_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   input wire logic wp_n,
   output logic so,
   output logic so_oe_n,
   output logic [15:0] status_word,
   output logic quad_mode,
   output logic security_locked,
   output logic array_start,
   output fsp_array_req_t array_req,
   output logic cmd_refused
);

   // ==========================================================================
   // Declarations
   // ==========================================================================
   fsp_frame_t frame;
   fsp_state_t state;
   fsp_op_t kind;
   logic [15:0] snap, cur_status;
   logic [11:0] busy_cnt;
   logic [7:0] op;
   logic [4:0] block_guard_bits;
   logic cs_meta, cs_sync, cs_prev, wp_meta, wp_sync, frame_end, busy_flag, write_latch;
   logic sr_guard_lo, sr_guard_hi, quad_enable_bit, security_lock_bit, high_perf_flag;
   logic complement_protect, paused_op_flag, reset_armed, busy_is_sr, aligned, single, idle;
   logic sr_open, write_class, form_ok, region_ok, do_latch_set, do_latch_clr, do_sr_write;
   logic do_array, do_suspend, do_resume, do_arm, do_reset, do_perf_on, do_perf_off;

   // ==========================================================================
   // Functions
   // ==========================================================================
   function automatic logic in_guard(input logic [4:0] bp, input logic cmp,
                                     input logic [5:0] sec);
      logic hit;
      logic [3:0] k;
      hit = 1'b0;
      k = 4'h0;
      if (!bp[4]) begin
         case (bp[1:0])
            2'b00: hit = 1'b0;
            2'b11: hit = 1'b1;
            2'b01: hit = bp[3] ? (sec[5:4] == 2'b00) : (sec[5:4] == 2'b11);
            default: hit = bp[3] ? !sec[5] : sec[5];
         endcase
      end else begin
         case (bp[2:0])
            3'b000: k = 4'h0;
            3'b001: k = 4'h1;
            3'b010: k = 4'h2;
            3'b011: k = 4'h4;
            default: k = 4'h8;
         endcase
         if (bp[2:0] == 3'b111) begin
            hit = 1'b1;
         end else if (k == 4'h0) begin
            hit = 1'b0;
         end else if (bp[3]) begin
            hit = (sec < {2'b00, k});
         end else begin
            hit = ({1'b0, sec} >= (SECTOR_COUNT - {3'b000, k}));
         end
      end
      return hit ^ cmp;
   endfunction

   function automatic logic sr_write_open(input logic hi, input logic lo,
                                          input logic pin_low);
      logic ok;
      case ({hi, lo})
         2'b00: ok = 1'b1;
         2'b01: ok = !pin_low;
         2'b10: ok = 1'b0;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // ==========================================================================
   // Serial-clock side
   // ==========================================================================
   fsp_link u_link (
      .sclk(sclk),
      .cs_n(cs_n),
      .si(si),
      .snap(snap),
      .frame(frame),
      .so(so),
      .so_oe_n(so_oe_n)
   );

   // ==========================================================================
   // Pin synchronisers and end-of-frame detect
   // ==========================================================================
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_prev <= 1'b1;
         wp_meta <= 1'b1;
         wp_sync <= 1'b1;
      end else begin
         cs_meta <= cs_n;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
         wp_meta <= wp_n;
         wp_sync <= wp_meta;
      end
   end

   // The frame fields stand still once select is high, so they are read here.
   assign frame_end = cs_sync && !cs_prev;

   // The snapshot is frozen while a frame is open so the link reads a stable word.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         snap <= STATUS_RESET;
      end else if (cs_sync) begin
         snap <= cur_status;
      end
   end

   // ==========================================================================
   // Status word assembly
   // ==========================================================================
   always_comb begin
      cur_status = 16'h0000;
      cur_status[BIT_BUSY] = busy_flag;
      cur_status[BIT_LATCH] = write_latch;
      cur_status[BIT_GUARD_LO +: 5] = block_guard_bits;
      cur_status[BIT_SR_GUARD_LO] = sr_guard_lo;
      cur_status[BIT_SR_GUARD_HI] = sr_guard_hi;
      cur_status[BIT_QUAD] = quad_enable_bit;
      cur_status[BIT_SEC_LOCK] = security_lock_bit;
      cur_status[BIT_PERF] = high_perf_flag;
      cur_status[BIT_COMPL] = complement_protect;
      cur_status[BIT_PAUSED] = paused_op_flag;
   end

   assign busy_flag = (state == FSP_BUSY);

   // ==========================================================================
   // Command decode
   // ==========================================================================
   assign op = frame.opcode;
   assign aligned = (frame.bitpos == 3'h0);
   assign single = aligned && (frame.bytes == BYTES_SINGLE);
   assign idle = (state == FSP_IDLE);
   // With quad enabled the protect pin carries data and never protects.
   assign sr_open = sr_write_open(sr_guard_hi, sr_guard_lo,
                                  !wp_sync && !quad_enable_bit);

   always_comb begin
      case (op)
         CMD_PAGE_WRITE, CMD_QUAD_PAGE_WRITE: kind = FSP_OP_PROG;
         CMD_ERASE_4K: kind = FSP_OP_ERASE_4K;
         CMD_ERASE_32K: kind = FSP_OP_ERASE_32K;
         CMD_ERASE_64K: kind = FSP_OP_ERASE_64K;
         CMD_ERASE_ALL_A, CMD_ERASE_ALL_B: kind = FSP_OP_ERASE_ALL;
         default: kind = FSP_OP_NONE;
      endcase
   end

   always_comb begin
      if (kind == FSP_OP_PROG) begin
         form_ok = aligned && (frame.bytes >= BYTES_PROG_MIN) &&
                   (op == CMD_PAGE_WRITE || quad_enable_bit);
      end else if (kind == FSP_OP_ERASE_ALL) begin
         form_ok = single;
      end else if (kind != FSP_OP_NONE) begin
         form_ok = aligned && (frame.bytes == BYTES_ERASE);
      end else begin
         form_ok = (op == CMD_STATUS_WRITE) && aligned &&
                   (frame.bytes == BYTES_SR_ONE || frame.bytes == BYTES_SR_TWO);
      end
   end

   assign region_ok = (kind == FSP_OP_ERASE_ALL) ?
                      (block_guard_bits[2:0] == {3{complement_protect}}) :
                      !in_guard(block_guard_bits, complement_protect, frame.addr[17:12]);

   assign write_class = frame_end && idle && form_ok;
   assign do_sr_write = write_class && (op == CMD_STATUS_WRITE) &&
                        write_latch && sr_open;
   assign do_array = write_class && (kind != FSP_OP_NONE) &&
                     write_latch && region_ok;
   assign do_latch_set = frame_end && single && (op == CMD_WR_ENABLE) && !busy_flag;
   assign do_latch_clr = (frame_end && single && (op == CMD_WR_DISABLE)) || write_class;
   assign do_suspend = frame_end && single && (op == CMD_SUSPEND) && busy_flag && !busy_is_sr;
   assign do_resume = frame_end && single && (op == CMD_RESUME) && (state == FSP_PAUSED);
   assign do_arm = frame_end && single && (op == CMD_RESET_ARM);
   assign do_reset = frame_end && single && (op == CMD_RESET_GO) && reset_armed;
   assign do_perf_on = frame_end && single && (op == CMD_PERF_ENTER) && idle;
   assign do_perf_off = frame_end && single && (op == CMD_PERF_EXIT) && idle;

   // ==========================================================================
   // Operation state and busy timer
   // ==========================================================================
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= FSP_IDLE;
         busy_cnt <= 12'h000;
         busy_is_sr <= 1'b0;
      end else if (do_reset) begin
         state <= FSP_IDLE;
         busy_cnt <= 12'h000;
         busy_is_sr <= 1'b0;
      end else begin
         case (state)
            FSP_IDLE: begin
               if (do_sr_write || do_array) begin
                  state <= FSP_BUSY;
                  busy_cnt <= OP_CYCLES;
                  busy_is_sr <= do_sr_write;
               end
            end
            FSP_BUSY: begin
               if (do_suspend) begin
                  state <= FSP_PAUSED;
               end else if (busy_cnt <= 12'h001) begin
                  state <= FSP_IDLE;
                  busy_cnt <= 12'h000;
               end else begin
                  busy_cnt <= busy_cnt - 12'h001;
               end
            end
            FSP_PAUSED: begin
               if (do_resume) begin
                  state <= FSP_BUSY;
               end
            end
            default: begin
               state <= FSP_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // Write latch
   // ==========================================================================
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         write_latch <= 1'b0;
      end else if (do_reset || do_latch_clr) begin
         write_latch <= 1'b0;
      end else if (do_latch_set) begin
         write_latch <= 1'b1;
      end
   end

   // ==========================================================================
   // Protection and configuration bits
   // ==========================================================================
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         block_guard_bits <= 5'h00;
         sr_guard_lo <= 1'b0;
         sr_guard_hi <= 1'b0;
         quad_enable_bit <= 1'b0;
         security_lock_bit <= 1'b0;
         complement_protect <= 1'b0;
      end else if (do_sr_write) begin
         block_guard_bits <= frame.addr[BIT_GUARD_LO + 16 +: 5];
         sr_guard_lo <= frame.addr[BIT_SR_GUARD_LO + 16];
         if (frame.bytes == BYTES_SR_TWO) begin
            sr_guard_hi <= frame.addr[BIT_SR_GUARD_HI];
            quad_enable_bit <= frame.addr[BIT_QUAD];
            security_lock_bit <= security_lock_bit | frame.addr[BIT_SEC_LOCK];
            complement_protect <= frame.addr[BIT_COMPL];
         end
      end
   end

   // ==========================================================================
   // Volatile flags
   // ==========================================================================
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         high_perf_flag <= 1'b0;
      end else if (do_reset || do_perf_off) begin
         high_perf_flag <= 1'b0;
      end else if (do_perf_on) begin
         high_perf_flag <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         paused_op_flag <= 1'b0;
      end else if (do_suspend) begin
         paused_op_flag <= 1'b1;
      end else if (do_resume || do_reset) begin
         paused_op_flag <= 1'b0;
      end
   end

   // The reset pair must be back to back; any other frame disarms it.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reset_armed <= 1'b0;
      end else if (frame_end) begin
         reset_armed <= do_arm;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         status_word <= STATUS_RESET;
         quad_mode <= 1'b0;
         security_locked <= 1'b0;
      end else begin
         status_word <= cur_status;
         quad_mode <= quad_enable_bit;
         security_locked <= security_lock_bit;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         array_start <= 1'b0;
         array_req <= '{kind: FSP_OP_NONE, addr: 24'h000000};
         cmd_refused <= 1'b0;
      end else begin
         array_start <= do_array;
         if (do_array) begin
            array_req <= '{kind: kind, addr: frame.addr};
         end
         cmd_refused <= write_class && !do_sr_write && !do_array;
      end
   end

endmodule
`default_nettype wire

/* File: tb/fsp_props.sv */
// Port checks for the flash status and write-protect block.
`timescale 1ns/100ps
`default_nettype none
module fsp_props import fsp_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] status_word,
   input wire logic security_locked,
   input wire logic array_start,
   input wire fsp_array_req_t array_req,
   input wire logic cmd_refused
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   reserved_zero_a: assert property (status_word[12:11] == 2'h0)
      else $error("reserved bits set");
   start_busy_a: assert property (array_start |=> status_word[0] && !status_word[1])
      else $error("start without busy or with latch");
   start_latch_a: assert property (array_start |-> $past(status_word[1]))
      else $error("start without latch");
   busy_bound_a: assert property ($rose(status_word[0]) |-> ##[1:130] !status_word[0])
      else $error("busy never ended");
   lock_sticky_a: assert property (!$fell(security_locked))
      else $error("security lock cleared");
   guard_freeze_a: assert property (status_word[8] |=> $stable(status_word[10:2]))
      else $error("locked status changed");
   erase_all_a: assert property (array_start && array_req.kind == FSP_OP_ERASE_ALL |->
      $past(status_word[4:2]) == {3{$past(status_word[14])}})
      else $error("whole erase with bad guard");
   refuse_excl_a: assert property (cmd_refused |-> !array_start)
      else $error("refused and started together");
   cover property (array_start);
   cover property (cmd_refused);
   cover property (status_word[15]);
endmodule
`default_nettype wire

/* File: tb/fsp_host.sv */
// Serial host model that clocks frames into the status block.
`timescale 1ns/100ps
`default_nettype none
module fsp_host (
   output logic sclk,
   output logic cs_n,
   output logic si,
   input wire logic so
);
   initial begin
      sclk = 1'b0;
      si = 1'b1;
      #1 cs_n = 1'b1;
   end
   // Sends n bits MSB first from the top of d; rd keeps the last eight bits read.
   task automatic xfer(input logic [39:0] d, input int n, output logic [7:0] rd);
      rd = 8'h00;
      cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         si = d[39 - i];
         #40 sclk = 1'b1;
         rd = {rd[6:0], so};
         #40 sclk = 1'b0;
      end
      #40 cs_n = 1'b1;
      si = ~si; // A released line must not show its last value.
      #200;
   endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the flash status and write-protect block.
`timescale 1ns/100ps
`default_nettype none
module testbench import fsp_pkg::*;;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wp_n = 1'b1;
   wire sclk, cs_n, si, so, so_oe_n;
   logic [15:0] status_word;
   logic quad_mode, security_locked, array_start, cmd_refused;
   fsp_array_req_t array_req;
   logic [7:0] rd;
   int err_total = 0, num_checks = 0, n_start = 0, n_ref = 0, cycles = 0, n_oe = 0;
   always #10 core_clk = ~core_clk;
   fsp_status_protect u_fsp_status_protect (.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk),
      .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .status_word(status_word),
      .quad_mode(quad_mode), .security_locked(security_locked), .array_start(array_start),
      .array_req(array_req), .cmd_refused(cmd_refused));
   fsp_host u_fsp_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (array_start === 1'b1) n_start <= n_start + 1;
      if (cmd_refused === 1'b1) n_ref <= n_ref + 1;
      if (cycles == 30000) begin
         err_total = err_total + 1;
         final_report();
      end
   end
   always @(posedge sclk) begin
      if (so_oe_n === 1'b0) n_oe <= n_oe + 1;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [39:0] d, input int n);
      u_fsp_host.xfer(d, n, rd);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 200 && status_word[0] !== 1'b0; i++) @(posedge core_clk);
      check(status_word[0], 1'b0);
   endtask
   task automatic wr_status(input logic [15:0] v);
      send({8'h06, 32'h0}, 8);
      send({8'h01, v[7:0], v[15:8], 16'h0}, 24);
      wait_idle();
   endtask
   task automatic t_latch();
      check(status_word, 16'h0000);
      check({quad_mode, security_locked}, 2'h0);
      send({8'h06, 32'h0}, 8);
      send({8'h05, 32'h0}, 16);
      check(rd, 8'h02);
      check({n_oe[7:0], so_oe_n}, 9'h011);
      send({8'h04, 32'h0}, 8);
      check(status_word[1], 1'b0);
      send({8'h02, 24'h0, 8'hAA}, 40);
      check({n_ref[7:0], n_start[7:0]}, 16'h0100);
      $display("test latch done");
   endtask
   task automatic t_region();
      wr_status(16'h4464);
      check({security_locked, status_word}, 17'h14464);
      send({8'h35, 32'h0}, 16);
      check(rd, 8'h44);
      send({8'h06, 32'h0}, 8);
      send({8'h02, 24'h001000, 8'hAA}, 40);
      check({n_ref[7:0], status_word[1]}, 9'h004);
      send({8'h06, 32'h0}, 8);
      send({8'h02, 24'h000000, 8'hAA}, 40);
      check(array_req, {FSP_OP_PROG, 24'h000000});
      send({8'h75, 32'h0}, 8);
      check(status_word[15:0], 16'hC464);
      send({8'h7A, 32'h0}, 8);
      check(status_word[15:0], 16'h4465);
      wait_idle();
      send({8'h06, 32'h0}, 8);
      send({8'hC7, 32'h0}, 8);
      check({n_ref[7:0], n_start[7:0]}, 16'h0301);
      $display("test region done");
   endtask
   task automatic t_lower();
      wr_status(16'h1804);
      check(status_word, 16'h0404);
      send({8'h06, 32'h0}, 8);
      send({8'hD8, 24'h030000, 8'h0}, 32);
      check(n_ref, 4);
      send({8'h06, 32'h0}, 8);
      send({8'h20, 24'h02F000, 8'h0}, 32);
      check(array_req, {FSP_OP_ERASE_4K, 24'h02F000});
      send({8'h75, 32'h0}, 8);
      send({8'h66, 32'h0}, 8);
      send({8'h99, 32'h0}, 8);
      check(status_word[15], 1'b0);
      wait_idle();
      $display("test lower done");
   endtask
   task automatic t_guard();
      wr_status(16'h0080);
      @(posedge core_clk);
      wp_n <= 1'b0;
      wr_status(16'h0088);
      check(status_word, 16'h0480);
      @(posedge core_clk);
      wp_n <= 1'b1;
      wr_status(16'h0088);
      check(status_word, 16'h0488);
      wr_status(16'h0100);
      wr_status(16'h0000);
      check(status_word, 16'h0500);
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      check({security_locked, status_word}, 17'h0);
      send({8'h06, 32'h0}, 8);
      send({8'hC7, 32'h0}, 8);
      check(array_req.kind, FSP_OP_ERASE_ALL);
      wait_idle();
      $display("test guard done");
   endtask
   task automatic t_modes();
      send({8'hA3, 32'h0}, 8);
      check(status_word[13], 1'b1);
      send({8'hAB, 32'h0}, 8);
      wr_status(16'h0280);
      @(posedge core_clk);
      wp_n <= 1'b0;
      wr_status(16'h0284);
      check({quad_mode, status_word}, 17'h10284);
      send({8'h06, 32'h0}, 8);
      send({8'h32, 24'h000000, 8'hAA}, 40);
      check(array_req, {FSP_OP_PROG, 24'h000000});
      wait_idle();
      send({8'h06, 32'h0}, 8);
      send({8'h52, 24'h010000, 8'h0}, 32);
      check(array_req, {FSP_OP_ERASE_32K, 24'h010000});
      wait_idle();
      wr_status(16'h0180);
      @(posedge core_clk);
      wp_n <= 1'b1;
      wr_status(16'h0000);
      check(status_word, 16'h0180);
      $display("test modes done");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      t_latch();
      t_region();
      t_lower();
      t_guard();
      t_modes();
      final_report();
   end
endmodule
bind fsp_status_protect fsp_props u_fsp_props (.core_clk(core_clk), .rst_n(rst_n),
   .status_word(status_word), .security_locked(security_locked), .array_start(array_start),
   .array_req(array_req), .cmd_refused(cmd_refused));
`default_nettype wire
